// file: design/branch_sysctl_regs.svh
`ifndef BRANCH_SYSCTL_REGS_SVH
`define BRANCH_SYSCTL_REGS_SVH
`define RESET_PC 32'h00000000
`define RESET_VBR 32'h00000000
`define VEC_TRAP_OFS 32'h00000100
`define VEC_ILLEGAL_OFS 32'h00000180
`define INSTR_BYTES 32'h00000002
`define BRANCH_BASE 32'h00000004
`define SR_T_BIT 0
`define SR_S_BIT 1
`define SR_MD_BIT 30
`define RESET_MD 1'b1
`define CTRL_SEL_STATUS 4'h0
`define CTRL_SEL_GBR 4'h1
`define CTRL_SEL_VBR 4'h2
`define CTRL_SEL_SSR 4'h3
`define CTRL_SEL_SPC 4'h4
`define SYS_SEL_MACH 4'h0
`define SYS_SEL_MACL 4'h1
`define SYS_SEL_PR 4'h2
`endif

// file: design/branch_sysctl_pkg.sv
package branch_sysctl_pkg;
    typedef enum logic [4:0] {
        OP_NOP, OP_BF, OP_BT, OP_BRA, OP_FAR_RELATIVE_JUMP_BY_REGISTER, OP_BSR, OP_CALL_RELATIVE_BY_REGISTER, OP_JMP,
        OP_JSR, OP_RTS, OP_RTE, OP_SOFTWARE_TRAP, OP_ACCUMULATOR_CLEAR, OP_TEST_FLAG_CLEAR, OP_TEST_FLAG_SET,
        OP_AUX_FLAG_CLEAR, OP_AUX_FLAG_SET, OP_LDC, OP_LDC_M, OP_STC, OP_STC_M, OP_LDS,
        OP_LDS_M, OP_STS, OP_STS_M, OP_PAGE_ENTRY_LOAD, OP_CACHE_FILL_HINT, OP_SLEEP, OP_ADDI,
        OP_LOAD
    } op_type;
    typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} size_type;
    typedef enum logic [1:0] {S_RUN = 2'h0, S_MEM = 2'h1, S_SLEEP = 2'h2} state_type;
    typedef struct packed {
        op_type op;
        logic delayed;
        size_type size;
        logic [3:0] source_reg_field;
        logic [3:0] dest_reg_field;
        logic [11:0] disp;
        logic [7:0] imm;
    } instr_type;
    typedef struct packed {
        logic valid;
        logic write;
        logic cache_fill_hint;
        size_type size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_type;
    typedef struct packed {
        logic md;
        logic s;
        logic t;
    } status_type;
    typedef struct packed {
        logic valid;
        logic illegal;
        logic [7:0] code;
    } exc_type;
endpackage

// file: design/op_classify.sv
`timescale 1ns/1ps
module op_classify
    import branch_sysctl_pkg::*;
(
    input instr_type instr,
    output logic priv,
    output logic mem_op,
    output logic [15:0] reads
);
    always_comb begin
        priv = 1'b0;
        mem_op = 1'b0;
        reads = 16'h0000;
        unique case (instr.op)
            OP_LDC, OP_LDC_M, OP_STC, OP_STC_M, OP_RTE, OP_SLEEP, OP_PAGE_ENTRY_LOAD: priv = 1'b1;
            default: priv = 1'b0;
        endcase
        unique case (instr.op)
            OP_LDC_M, OP_STC_M, OP_LDS_M, OP_STS_M, OP_CACHE_FILL_HINT, OP_LOAD: mem_op = 1'b1;
            default: mem_op = 1'b0;
        endcase
        unique case (instr.op)
            OP_FAR_RELATIVE_JUMP_BY_REGISTER, OP_CALL_RELATIVE_BY_REGISTER, OP_JMP, OP_JSR, OP_LDC, OP_LDS, OP_LDC_M, OP_LDS_M,
            OP_LOAD: reads[instr.source_reg_field] = 1'b1;
            OP_ADDI, OP_STC_M, OP_STS_M, OP_CACHE_FILL_HINT: reads[instr.dest_reg_field] = 1'b1;
            default: reads = 16'h0000;
        endcase
    end
endmodule

// file: design/branch_sysctl_instr_decode.sv
`timescale 1ns/1ps
`include "branch_sysctl_regs.svh"
module branch_sysctl_instr_decode
    import branch_sysctl_pkg::*;
(
    input logic ref_clk,
    input logic rstn,
    input instr_type instr_in,
    input logic instr_valid,
    output logic instr_ready_q,
    output logic [31:0] fetch_pc_q,
    input logic fetch_busy,
    output mem_req_type mem_req_q,
    input logic mem_ack,
    input logic [31:0] mem_rdata,
    input logic wake,
    output logic power_down_q,
    output logic page_entry_load_q,
    output status_type status_q,
    output exc_type exc_q,
    output logic [31:0] stall_cycles_q
);
    state_type state_q;
    logic [31:0] gpr_q [0:15];
    logic [31:0] gbr_q, vbr_q, ssr_q, spc_q, mach_q, macl_q, pr_q;
    logic slot_q;
    logic [31:0] slot_tgt_q;
    op_type pend_op_q;
    logic [3:0] pend_sel_q;
    size_type pend_size_q;
    logic priv, mem_op;
    logic [15:0] reads;
    logic taken, illegal, go, done;
    logic br, link, t_touch;
    logic [31:0] tgt, rm_v, rn_v, sdisp, pc_seq;
    logic gw, cw, sw;
    logic [3:0] gidx, csel, ssel;
    logic [31:0] gval, cval, sval;

    function automatic logic [31:0] scale(input logic [11:0] d, input size_type sz);
        logic [31:0] x;
        x = {{20{d[11]}}, d};
        unique case (sz)
            SZ_WORD: scale = {x[30:0], 1'b0};
            SZ_LONG: scale = {x[29:0], 2'b00};
            default: scale = x;
        endcase
    endfunction

    function automatic logic [31:0] sr_word(input status_type s);
        sr_word = 32'h00000000;
        sr_word[`SR_T_BIT] = s.t;
        sr_word[`SR_S_BIT] = s.s;
        sr_word[`SR_MD_BIT] = s.md;
    endfunction

    function automatic logic [31:0] ext_load(input logic [31:0] d, input size_type sz);
        unique case (sz)
            SZ_BYTE: ext_load = {{24{d[7]}}, d[7:0]};
            SZ_WORD: ext_load = {{16{d[15]}}, d[15:0]};
            default: ext_load = d;
        endcase
    endfunction

    op_classify u_class (
        .instr(instr_in),
        .priv(priv),
        .mem_op(mem_op),
        .reads(reads)
    );

    assign taken = instr_valid && instr_ready_q && (state_q == S_RUN);
    assign illegal = taken && priv && !status_q.md;
    assign go = taken && !illegal;
    assign done = (state_q == S_MEM) && mem_req_q.valid && mem_ack;
    assign rm_v = gpr_q[instr_in.source_reg_field];
    assign rn_v = gpr_q[instr_in.dest_reg_field];
    assign sdisp = scale(instr_in.disp, (instr_in.op == OP_LOAD) ? instr_in.size : SZ_LONG);
    assign pc_seq = slot_q ? slot_tgt_q : fetch_pc_q + `INSTR_BYTES;

    always_comb begin
        br = 1'b0;
        link = 1'b0;
        t_touch = 1'b0;
        tgt = fetch_pc_q + `BRANCH_BASE + scale(instr_in.disp, SZ_WORD);
        unique case (instr_in.op)
            OP_BF: br = !status_q.t;
            OP_BT: br = status_q.t;
            OP_BRA: br = 1'b1;
            OP_FAR_RELATIVE_JUMP_BY_REGISTER: begin
                br = 1'b1;
                tgt = fetch_pc_q + `BRANCH_BASE + rm_v;
            end
            OP_BSR: begin
                br = 1'b1;
                link = 1'b1;
            end
            OP_CALL_RELATIVE_BY_REGISTER: begin
                br = 1'b1;
                link = 1'b1;
                tgt = fetch_pc_q + `BRANCH_BASE + rm_v;
            end
            OP_JMP: begin
                br = 1'b1;
                tgt = rm_v;
            end
            OP_JSR: begin
                br = 1'b1;
                link = 1'b1;
                tgt = rm_v;
            end
            OP_RTS: begin
                br = 1'b1;
                tgt = pr_q;
            end
            OP_RTE: begin
                br = 1'b1;
                t_touch = 1'b1;
                tgt = spc_q;
            end
            OP_SOFTWARE_TRAP: begin
                br = 1'b1;
                tgt = vbr_q + `VEC_TRAP_OFS;
            end
            OP_TEST_FLAG_CLEAR, OP_TEST_FLAG_SET, OP_LDC, OP_LDC_M: t_touch = 1'b1;
            default: br = 1'b0;
        endcase
    end

    // one write port per register group, fed by decode or by load completion
    always_comb begin
        gw = 1'b0;
        gidx = instr_in.dest_reg_field;
        gval = rn_v + {{24{instr_in.imm[7]}}, instr_in.imm};
        if (done) begin
            gw = (pend_op_q == OP_LOAD);
            gidx = pend_sel_q;
            gval = ext_load(mem_rdata, pend_size_q);
        end else if (go) begin
            unique case (instr_in.op)
                OP_ADDI: gw = 1'b1;
                OP_STC: begin
                    gw = 1'b1;
                    unique case (instr_in.source_reg_field)
                        `CTRL_SEL_STATUS: gval = sr_word(status_q);
                        `CTRL_SEL_GBR: gval = gbr_q;
                        `CTRL_SEL_VBR: gval = vbr_q;
                        `CTRL_SEL_SSR: gval = ssr_q;
                        default: gval = spc_q;
                    endcase
                end
                OP_STS: begin
                    gw = 1'b1;
                    unique case (instr_in.source_reg_field)
                        `SYS_SEL_MACH: gval = mach_q;
                        `SYS_SEL_MACL: gval = macl_q;
                        default: gval = pr_q;
                    endcase
                end
                default: gw = 1'b0;
            endcase
        end
    end

    always_comb begin
        cw = go && (instr_in.op == OP_LDC);
        csel = instr_in.dest_reg_field;
        cval = rm_v;
        sw = go && (instr_in.op == OP_LDS);
        ssel = instr_in.dest_reg_field;
        sval = rm_v;
        if (done && pend_op_q == OP_LDC_M) begin
            cw = 1'b1;
            csel = pend_sel_q;
            cval = mem_rdata;
        end
        if (done && pend_op_q == OP_LDS_M) begin
            sw = 1'b1;
            ssel = pend_sel_q;
            sval = mem_rdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= S_RUN;
            instr_ready_q <= 1'b0;
            power_down_q <= 1'b0;
        end else begin
            unique case (state_q)
                S_RUN: begin
                    instr_ready_q <= !(go && (mem_op || instr_in.op == OP_SLEEP));
                    if (go && mem_op) begin
                        state_q <= S_MEM;
                    end else if (go && instr_in.op == OP_SLEEP) begin
                        state_q <= S_SLEEP;
                        power_down_q <= 1'b1;
                    end
                end
                S_MEM: begin
                    if (done) begin
                        state_q <= S_RUN;
                        // dependent follower waits one more cycle
                        instr_ready_q <= !(pend_op_q == OP_LOAD && instr_valid &&
                                           reads[pend_sel_q]);
                    end
                end
                S_SLEEP: begin
                    if (wake) begin
                        state_q <= S_RUN;
                        power_down_q <= 1'b0;
                        instr_ready_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= S_RUN;
                    instr_ready_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fetch_pc_q <= `RESET_PC;
            slot_q <= 1'b0;
            slot_tgt_q <= `RESET_PC;
        end else if (illegal) begin
            fetch_pc_q <= vbr_q + `VEC_ILLEGAL_OFS;
            slot_q <= 1'b0;
        end else if (go) begin
            // target waits behind the slot instruction in delayed form
            if (br && instr_in.delayed && instr_in.op != OP_SOFTWARE_TRAP) begin
                fetch_pc_q <= fetch_pc_q + `INSTR_BYTES;
                slot_q <= 1'b1;
                slot_tgt_q <= tgt;
            end else if (br) begin
                fetch_pc_q <= tgt;
                slot_q <= 1'b0;
            end else begin
                fetch_pc_q <= pc_seq;
                slot_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 16; i++) begin
                gpr_q[i] <= 32'h00000000;
            end
        end else if (gw) begin
            gpr_q[gidx] <= gval;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            status_q <= '{md: `RESET_MD, s: 1'b0, t: 1'b0};
            gbr_q <= 32'h00000000;
            vbr_q <= `RESET_VBR;
            ssr_q <= 32'h00000000;
            spc_q <= 32'h00000000;
        end else if (illegal) begin
            ssr_q <= sr_word(status_q);
            spc_q <= fetch_pc_q;
            status_q.md <= 1'b1;
        end else begin
            if (go) begin
                unique case (instr_in.op)
                    OP_TEST_FLAG_CLEAR: status_q.t <= 1'b0;
                    OP_TEST_FLAG_SET: status_q.t <= 1'b1;
                    OP_AUX_FLAG_CLEAR: status_q.s <= 1'b0;
                    OP_AUX_FLAG_SET: status_q.s <= 1'b1;
                    OP_SOFTWARE_TRAP: begin
                        ssr_q <= sr_word(status_q);
                        spc_q <= fetch_pc_q + `INSTR_BYTES;
                        status_q.md <= 1'b1;
                    end
                    OP_RTE: begin
                        status_q.t <= ssr_q[`SR_T_BIT];
                        status_q.s <= ssr_q[`SR_S_BIT];
                        status_q.md <= ssr_q[`SR_MD_BIT];
                    end
                    default: status_q <= status_q;
                endcase
            end
            if (cw) begin
                unique case (csel)
                    `CTRL_SEL_STATUS: begin
                        status_q.t <= cval[`SR_T_BIT];
                        status_q.s <= cval[`SR_S_BIT];
                        status_q.md <= cval[`SR_MD_BIT];
                    end
                    `CTRL_SEL_GBR: gbr_q <= cval;
                    `CTRL_SEL_VBR: vbr_q <= cval;
                    `CTRL_SEL_SSR: ssr_q <= cval;
                    default: spc_q <= cval;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mach_q <= 32'h00000000;
            macl_q <= 32'h00000000;
            pr_q <= 32'h00000000;
        end else begin
            if (go && instr_in.op == OP_ACCUMULATOR_CLEAR) begin
                mach_q <= 32'h00000000;
                macl_q <= 32'h00000000;
            end
            if (go && link) begin
                pr_q <= fetch_pc_q + `BRANCH_BASE;
            end
            if (sw) begin
                unique case (ssel)
                    `SYS_SEL_MACH: mach_q <= sval;
                    `SYS_SEL_MACL: macl_q <= sval;
                    default: pr_q <= sval;
                endcase
            end
        end
    end

    // data access yields the shared path to a fetch in progress
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mem_req_q <= '0;
            pend_op_q <= OP_NOP;
            pend_sel_q <= 4'h0;
            pend_size_q <= SZ_LONG;
        end else if (go && mem_op) begin
            mem_req_q.valid <= !fetch_busy;
            mem_req_q.write <= (instr_in.op == OP_STC_M) || (instr_in.op == OP_STS_M);
            mem_req_q.cache_fill_hint <= (instr_in.op == OP_CACHE_FILL_HINT);
            mem_req_q.size <= (instr_in.op == OP_LOAD) ? instr_in.size : SZ_LONG;
            mem_req_q.addr <= ((instr_in.op == OP_LOAD || instr_in.op == OP_LDC_M ||
                                instr_in.op == OP_LDS_M) ? rm_v : rn_v) + sdisp;
            mem_req_q.wdata <= (instr_in.op == OP_STC_M) ?
                               ((instr_in.source_reg_field == `CTRL_SEL_STATUS) ?
                                sr_word(status_q) : gbr_q) :
                               ((instr_in.source_reg_field == `SYS_SEL_MACH) ? mach_q :
                                (instr_in.source_reg_field == `SYS_SEL_MACL) ? macl_q : pr_q);
            pend_op_q <= instr_in.op;
            pend_sel_q <= instr_in.dest_reg_field;
            pend_size_q <= instr_in.size;
        end else if (done) begin
            mem_req_q.valid <= 1'b0;
        end else if (state_q == S_MEM && !mem_req_q.valid && !fetch_busy) begin
            mem_req_q.valid <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            exc_q <= '0;
            page_entry_load_q <= 1'b0;
            stall_cycles_q <= 32'h00000000;
        end else begin
            exc_q.valid <= illegal || (go && instr_in.op == OP_SOFTWARE_TRAP);
            exc_q.illegal <= illegal;
            exc_q.code <= instr_in.imm;
            page_entry_load_q <= go && (instr_in.op == OP_PAGE_ENTRY_LOAD);
            if ((state_q == S_MEM && !mem_req_q.valid) ||
                (state_q == S_RUN && !instr_ready_q)) begin
                stall_cycles_q <= stall_cycles_q + 32'h00000001;
            end
        end
    end

    a_bf_no_take: assert property (@(posedge ref_clk) disable iff (!rstn)
        go && instr_in.op == OP_BF && status_q.t && !slot_q |=>
        fetch_pc_q == $past(fetch_pc_q) + `INSTR_BYTES) else $error("bf taken with t set");
    a_call_link: assert property (@(posedge ref_clk) disable iff (!rstn)
        go && instr_in.op == OP_BSR |=> pr_q == $past(fetch_pc_q) + `BRANCH_BASE)
        else $error("call link wrong");
    a_t_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
        go && !t_touch && !done |=> $stable(status_q.t)) else $error("t changed");
    a_req_yields: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(mem_req_q.valid) |-> !$past(fetch_busy)) else $error("request during fetch");
    a_load_stall: assert property (@(posedge ref_clk) disable iff (!rstn)
        done && pend_op_q == OP_LOAD && instr_valid && reads[pend_sel_q] |=>
        !instr_ready_q ##1 instr_ready_q) else $error("load use not stalled");
    a_priv_refused: assert property (@(posedge ref_clk) disable iff (!rstn)
        taken && priv && !status_q.md |=> exc_q.valid && exc_q.illegal &&
        fetch_pc_q == $past(vbr_q) + `VEC_ILLEGAL_OFS) else $error("privilege not refused");
    a_trap_entry: assert property (@(posedge ref_clk) disable iff (!rstn)
        go && instr_in.op == OP_SOFTWARE_TRAP |=> status_q.md && exc_q.valid &&
        fetch_pc_q == $past(vbr_q) + `VEC_TRAP_OFS) else $error("trap entry wrong");
    // an early wake may end the sleep after one cycle
    a_sleep_enter: assert property (@(posedge ref_clk) disable iff (!rstn)
        go && instr_in.op == OP_SLEEP |=> (power_down_q && !instr_ready_q) ##1
        ((power_down_q && !instr_ready_q) || $past(wake)))
        else $error("sleep not entered");
    a_mac_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        go && instr_in.op == OP_ACCUMULATOR_CLEAR |=> mach_q == 32'h00000000 && macl_q == 32'h00000000)
        else $error("accumulator not cleared");
    a_addi_sum: assert property (@(posedge ref_clk) disable iff (!rstn)
        go && instr_in.op == OP_ADDI |=> gpr_q[$past(instr_in.dest_reg_field)] ==
        $past(rn_v) + {{24{$past(instr_in.imm[7])}}, $past(instr_in.imm)})
        else $error("add immediate wrong");
endmodule

// file: bench/mem_partner.sv
`timescale 1ns/1ps
module mem_partner
    import branch_sysctl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input mem_req_type req,
    input wire logic [1:0] lag,
    input wire logic [31:0] fill,
    output logic ack,
    output logic [31:0] rdata
);
    logic [1:0] wait_q;
    // read data toggles outside the ack cycle so stale data never passes for valid
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 2'h0;
            ack <= 1'b0;
            rdata <= 32'h0;
        end else if (req.valid && !ack && wait_q == lag) begin
            wait_q <= 2'h0;
            ack <= 1'b1;
            rdata <= fill;
        end else begin
            ack <= 1'b0;
            rdata <= ~rdata;
            if (req.valid && !ack) wait_q <= wait_q + 2'h1;
        end
    end
endmodule

// file: bench/branch_sysctl_instr_decode_bench.sv
`timescale 1ns/1ps
`include "branch_sysctl_regs.svh"
module branch_sysctl_instr_decode_bench
    import branch_sysctl_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    instr_type instr_in = '0;
    logic instr_valid = 1'b0;
    logic fetch_busy = 1'b0;
    logic wake = 1'b0;
    logic [1:0] lag = 2'h0;
    logic [31:0] fill = 32'h0;
    logic instr_ready_q, mem_ack, power_down_q, page_entry_load_q;
    logic [31:0] fetch_pc_q, mem_rdata, stall_cycles_q, pc_taken;
    mem_req_type mem_req_q;
    status_type status_q;
    exc_type exc_q;
    int failures = 0;
    int compares = 0;
    int n;
    logic [31:0] rng = 32'h4be3;
    op_type ft[7] = '{OP_TEST_FLAG_CLEAR, OP_TEST_FLAG_SET, OP_AUX_FLAG_CLEAR, OP_AUX_FLAG_SET, OP_NOP, OP_BT, OP_BF};
    op_type bt[6] = '{OP_BRA, OP_JMP, OP_FAR_RELATIVE_JUMP_BY_REGISTER, OP_JSR, OP_CALL_RELATIVE_BY_REGISTER, OP_BSR};
    op_type pv[5] = '{OP_LDC, OP_STC, OP_RTE, OP_SLEEP, OP_PAGE_ENTRY_LOAD};
    logic [3:0] rg[2] = '{4'h0, 4'hf};

    always #2.5 ref_clk = ~ref_clk;

    branch_sysctl_instr_decode u_dut (.ref_clk(ref_clk), .rstn(rstn), .instr_in(instr_in),
        .instr_valid(instr_valid), .instr_ready_q(instr_ready_q), .fetch_pc_q(fetch_pc_q),
        .fetch_busy(fetch_busy), .mem_req_q(mem_req_q), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .wake(wake), .power_down_q(power_down_q),
        .page_entry_load_q(page_entry_load_q), .status_q(status_q), .exc_q(exc_q),
        .stall_cycles_q(stall_cycles_q));
    mem_partner u_mem (.ref_clk(ref_clk), .rstn(rstn), .req(mem_req_q), .lag(lag),
        .fill(fill), .ack(mem_ack), .rdata(mem_rdata));

    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic logic [31:0] tgt(logic [31:0] p, logic [11:0] d);
        return p + `BRANCH_BASE + {{19{d[11]}}, d, 1'b0};
    endfunction
    function automatic instr_type mk(op_type op, logic [3:0] rm, logic [3:0] rn,
        logic [11:0] d, size_type sz = SZ_LONG, logic [7:0] im = 8'h0);
        return '{op: op, delayed: 1'b0, size: sz, source_reg_field: rm, dest_reg_field: rn,
            disp: d, imm: im};
    endfunction
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // called at a rising edge; returns at the edge that takes the instruction
    task automatic run(instr_type i);
        // valid was just lowered in this step: let an edge pass first
        if (instr_valid === 1'b1) @(posedge ref_clk);
        n = 0;
        instr_in <= i;
        instr_valid <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (instr_ready_q !== 1'b1 && n < 40);
        if (instr_ready_q !== 1'b1) failures++;
        pc_taken = fetch_pc_q;
        instr_valid <= 1'b0;
    endtask
    // the nop waits out the load so fill is not changed under it
    task automatic setr(logic [3:0] r, logic [31:0] v);
        fill <= v;
        run(mk(OP_LOAD, 4'h0, r, 12'h0));
        run(mk(OP_NOP, 4'h0, 4'h0, 12'h0));
    endtask
    task automatic mreq(instr_type i, logic [31:0] a, logic pf);
        int k = 0;
        run(i);
        while (mem_req_q.valid !== 1'b1 && k < 20) begin
            @(posedge ref_clk);
            k++;
        end
        if (mem_req_q.valid !== 1'b1) failures++;
        check(mem_req_q.addr, a);
        check(32'(mem_req_q.cache_fill_hint), 32'(pf));
        check(32'(mem_req_q.write), 32'(i.op inside {OP_STC_M, OP_STS_M}));
    endtask
    task automatic lp(instr_type nxt, logic fb, output int c);
        fetch_busy <= fb;
        run(mk(OP_LOAD, 4'h3, 4'h5, 12'h0));
        fork
            run(nxt);
            begin
                repeat (3) @(posedge ref_clk);
                fetch_busy <= 1'b0;
            end
        join
        c = n;
    endtask

    initial begin
        #100000;
        failures++;
        give_verdict();
    end

    initial begin
        logic [31:0] r, b, p, st, e;
        logic tv, sv;
        int c0, c1, c2, c3;
        instr_type ins;
        op_type o;
        tv = 1'b0;
        sv = 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        for (int k = 0; k < 40; k++) begin
            r = rnd();
            o = ft[r % 7];
            run(mk(o, 4'h0, 4'h0, r[19:8]));
            @(posedge ref_clk);
            if (o == OP_BT || o == OP_BF) begin
                e = ((o == OP_BT) == tv) ? tgt(pc_taken, r[19:8]) : pc_taken + `INSTR_BYTES;
                check(fetch_pc_q, e);
            end else begin
                tv = (o == OP_TEST_FLAG_SET) ? 1'b1 : (o == OP_TEST_FLAG_CLEAR) ? 1'b0 : tv;
                sv = (o == OP_AUX_FLAG_SET) ? 1'b1 : (o == OP_AUX_FLAG_CLEAR) ? 1'b0 : sv;
                check(32'(status_q), {29'h0, 1'b1, sv, tv});
            end
        end
        ins = mk(tv ? OP_BT : OP_BF, 4'h0, 4'h0, 12'h010);
        ins.delayed = 1'b1;
        run(ins);
        p = pc_taken;
        @(posedge ref_clk);
        check(fetch_pc_q, p + `INSTR_BYTES);
        run(mk(OP_NOP, 4'h0, 4'h0, 12'h0));
        @(posedge ref_clk);
        check(fetch_pc_q, tgt(p, 12'h010));
        for (int j = 0; j < 2; j++) begin
            b = rnd() & 32'hfffe;
            setr(rg[j], b);
            run(mk(OP_ADDI, 4'h0, rg[j], 12'h0, SZ_LONG, 8'h2a));
            b = b + 32'h2a;
            for (int k = 0; k < 6; k++) begin
                r = rnd();
                run(mk(bt[k], rg[j], rg[j], r[11:0]));
                p = pc_taken;
                @(posedge ref_clk);
                e = (bt[k] inside {OP_JMP, OP_JSR}) ? b : p + `BRANCH_BASE + b;
                if (bt[k] inside {OP_BRA, OP_BSR}) e = tgt(p, r[11:0]);
                check(fetch_pc_q, e);
                if (k > 2) begin
                    run(mk(OP_RTS, 4'h0, 4'h0, 12'h0));
                    @(posedge ref_clk);
                    check(fetch_pc_q, p + `BRANCH_BASE);
                end
            end
        end
        lp(mk(OP_NOP, 4'h0, 4'h0, 12'h0), 1'b0, c0);
        lp(mk(OP_JMP, 4'h5, 4'h5, 12'h0), 1'b0, c1);
        check(32'(c1), 32'(c0 + 1));
        st = stall_cycles_q;
        lp(mk(OP_NOP, 4'h0, 4'h0, 12'h0), 1'b1, c2);
        check(32'(c2 > c0 + 1 && stall_cycles_q - st > 1), 32'h1);
        lag <= 2'h3;
        lp(mk(OP_NOP, 4'h0, 4'h0, 12'h0), 1'b0, c3);
        lag <= 2'h0;
        check(32'(c3), 32'(c0 + 3));
        b = rnd() & 32'hfff0;
        setr(4'h1, b);
        for (int k = 0; k < 3; k++) begin
            r = rnd();
            e = b + (32'(r[7:0]) << k);
            mreq(mk(OP_LOAD, 4'h1, 4'h2, {4'h0, r[7:0]}, size_type'(k)), e, 1'b0);
        end
        mreq(mk(OP_CACHE_FILL_HINT, 4'h0, 4'h1, 12'h3), b + 32'hc, 1'b1);
        run(mk(OP_JMP, 4'h1, 4'h1, 12'h0));
        @(posedge ref_clk);
        check(fetch_pc_q, b);
        run(mk(OP_LDS, 4'h1, 4'h1, 12'h0));
        mreq(mk(OP_STS_M, 4'h1, 4'h1, 12'h0), b, 1'b0);
        check(mem_req_q.wdata, b);
        run(mk(OP_ACCUMULATOR_CLEAR, 4'h0, 4'h0, 12'h0));
        mreq(mk(OP_STS_M, 4'h1, 4'h1, 12'h0), b, 1'b0);
        check(mem_req_q.wdata, 32'h0);
        mreq(mk(OP_STC_M, 4'h0, 4'h1, 12'h0), b, 1'b0);
        check(mem_req_q.wdata, {2'b01, 28'h0, sv, tv});
        mreq(mk(OP_LDC_M, 4'h1, 4'h1, 12'h2), b + 32'h8, 1'b0);
        mreq(mk(OP_STC_M, 4'h1, 4'h1, 12'h0), b, 1'b0);
        check(mem_req_q.wdata, b);
        mreq(mk(OP_LDS_M, 4'h1, 4'h0, 12'h1), b + 32'h4, 1'b0);
        mreq(mk(OP_STS_M, 4'h0, 4'h1, 12'h0), b, 1'b0);
        check(mem_req_q.wdata, b);
        run(mk(OP_TEST_FLAG_SET, 4'h0, 4'h0, 12'h0));
        r = rnd();
        run(mk(OP_SOFTWARE_TRAP, 4'h0, 4'h0, 12'h0, SZ_LONG, r[7:0]));
        p = pc_taken;
        @(posedge ref_clk);
        check(32'(exc_q), {22'h0, 2'b10, r[7:0]});
        check(fetch_pc_q, `RESET_VBR + `VEC_TRAP_OFS);
        run(mk(OP_TEST_FLAG_CLEAR, 4'h0, 4'h0, 12'h0));
        run(mk(OP_RTE, 4'h0, 4'h0, 12'h0));
        @(posedge ref_clk);
        check(fetch_pc_q, p + `INSTR_BYTES);
        check(32'(status_q), {29'h0, 1'b1, sv, 1'b1});
        run(mk(OP_SLEEP, 4'h0, 4'h0, 12'h0));
        @(posedge ref_clk);
        check(32'({power_down_q, instr_ready_q}), 32'h2);
        wake <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check(32'(power_down_q), 32'h0);
        wake <= 1'b0;
        run(mk(OP_PAGE_ENTRY_LOAD, 4'h0, 4'h0, 12'h0));
        @(posedge ref_clk);
        check(32'(page_entry_load_q), 32'h1);
        setr(4'h2, 32'h0);
        run(mk(OP_LDC, 4'h2, 4'h0, 12'h0));
        @(posedge ref_clk);
        check(32'(status_q), 32'h0);
        for (int k = 0; k < 5; k++) begin
            run(mk(OP_TEST_FLAG_SET, 4'h0, 4'h0, 12'h0));
            @(posedge ref_clk);
            check(32'({exc_q.valid, status_q}), 32'h1);
            run(mk(pv[k], 4'h2, 4'h2, 12'h0));
            @(posedge ref_clk);
            e = 32'({exc_q.valid, exc_q.illegal, status_q.md, power_down_q, page_entry_load_q});
            check(e, 32'h1c);
            check(fetch_pc_q, `RESET_VBR + `VEC_ILLEGAL_OFS);
            run(mk(OP_LDC, 4'h2, 4'h0, 12'h0));
        end
        give_verdict();
    end
endmodule
